// File: rtl/csp_defs.svh
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSP_OFS_OPTION 8'h00
`define CSP_OFS_VOLT 8'h04
`define CSP_OFS_CURR 8'h08
`define CSP_OFS_INCUR 8'h0c
`define CSP_OFS_STATUS 8'h10
// ----------------------------------------
// Option word fields and reset value
// ----------------------------------------
`define CSP_OPT_INHIBIT 0
`define CSP_OPT_MONSEL 5
`define CSP_OPT_CALIB 6
`define CSP_OPT_DEPL_LO 11
`define CSP_OPT_WDT_LO 13
`define CSP_OPT_RST 16'h6000
// ----------------------------------------
// Setting ranges, mA and mV codes
// ----------------------------------------
`define CSP_VOLT_MASK 16'h7ff0
`define CSP_VOLT_MAX 16'h4b00
`define CSP_CURR_MASK 16'h1fc0
`define CSP_INCUR_MASK 16'h1f80
// Depletion fractions, scaled by 2^14
`define CSP_DEPL_K0 16'h25e2
`define CSP_DEPL_K1 16'h2819
`define CSP_DEPL_K2 16'h2a97
`define CSP_DEPL_K3 16'h2d6c
// ----------------------------------------
// Status bits
// ----------------------------------------
`define CSP_ST_CHARGE 0
`define CSP_ST_WDEXP 1
`define CSP_ST_ADPVALID 2
`define CSP_ST_ADPSW 3
`define CSP_ST_BATSW 4
`define CSP_ST_CALIB 5
`define CSP_ST_MONVALID 6
`define CSP_ST_TARGET_LO 16
// ----------------------------------------
// Timing
// ----------------------------------------
`define CSP_CLK_NS 10
`define CSP_SS_STEP_US 240
`define CSP_SS_STEP_CYCLES (`CSP_SS_STEP_US * 1000 / `CSP_CLK_NS)
`define CSP_WDT_TICK_MS 1
`define CSP_WDT_TICK_CYCLES (`CSP_WDT_TICK_MS * 1000000 / `CSP_CLK_NS)
`define CSP_WDT_MS_SHORT 18'h0abe0
`define CSP_WDT_MS_MID 18'h157c0
`define CSP_WDT_MS_LONG 18'h2ab98
`define CSP_SS_START 13'h0080
`define CSP_SS_STEP 13'h0040
`define CSP_BBM_CYCLES 8'h04
`define CSP_PWM_PERIOD 8'h85
`define CSP_PWM_DEAD 8'h01
`define CSP_PWM_REFRESH 8'h01
`define CSP_RAMP_OFFSET 8'h14
`endif

// File: rtl/csp_pkg.sv
package csp_pkg;
  typedef enum logic [1:0] {PS_BATT, PS_TO_ADPT, PS_ADPT, PS_TO_BATT} csp_power_e;
  typedef enum logic [1:0] {PW_DEAD_LOW, PW_HIGH, PW_DEAD_HIGH, PW_LOW} csp_pwm_e;
  typedef struct packed {
    logic supplyOk;
    logic adapterAboveReset;
    logic adapterAboveLow;
    logic adapterAboveOvp;
    logic limitAboveHigh;
    logic limitAboveLow;
    logic batteryOvervoltage;
    logic thermalShutdown;
    logic inputOvercurrent;
    logic shortDetected;
    logic gateDriveGood;
    logic bootstrapLow;
  } csp_cmp_s;
  typedef struct packed {
    logic [7:0] inputLoop;
    logic [7:0] chargeLoop;
    logic [7:0] voltageLoop;
  } csp_err_s;
  typedef struct packed {
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] sync3;
    logic [11:0] cmpFilt;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] option;
    logic [15:0] voltSet;
    logic [15:0] currSet;
    logic [15:0] inCurSet;
    csp_power_e ps;
    logic [7:0] bbmCnt;
    logic adapterValid;
    logic monitorValid;
    logic chargeOn;
    logic [12:0] ssTarget;
    logic [15:0] ssCnt;
    logic [16:0] tickCnt;
    logic [17:0] wdMs;
    logic wdExpired;
    csp_pwm_e pw;
    logic [7:0] rampCnt;
    logic [7:0] deadCnt;
    logic highSideOn;
    logic lowSideOn;
  } csp_state_s;
endpackage

// File: rtl/csp_charger_supervisor.sv
`include "csp_defs.svh"
// Contract
// - Option bit 6 set starts a calibration discharge; clear means none runs.
// - Calibration on adapter power turns adapter switches off and battery switch on.
// - Battery below depletion threshold ends calibration, returning to adapter power.
// - Finished calibration clears option bit 6 by itself.
// - Option bits 12:11 pick one of four depletion fractions of voltage setting.
// - Option bit 0 inhibits charging; reset value allows it.
// - Charging starts above upper current-limit level, stops below lower level.
// - All three settings must be valid to start; invalid one stops charging.
// - Start needs adapter valid, adapter switches on, no fault conditions.
// - Adapter loss, switch off, overvoltage, thermal, overcurrent or short stop charging.
// - Expired enabled watchdog stops charging.
// - Each charge start ramps target from 128 mA in 64 mA steps.
// - Each step lasts 240 us until the programmed current is reached.
// - Option bit 5 selects input or charge current for the monitor.
// - Monitor output valid only with supply ok and adapter above reset level.
// - No voltage or current write within timeout suspends charging; default longest.
// - Timeout keeps registers; host rewrites voltage or current to resume.
// - Option bits 14:13 select disabled, 44 s, 88 s or 175 s.
// - Disabling the watchdog after timeout also resumes charging.
// - Duty comes from ramp, with offset, compared to largest loop error.
// - Low bootstrap supply forces a low-side refresh, limiting maximum duty.
// - High side on while error exceeds ramp, then low side, with dead time.
// - Adapter valid needs supply ok and adapter detect inside its window.
module csp_charger_supervisor #(
  parameter int unsigned SS_STEP_CYCLES = `CSP_SS_STEP_CYCLES,
  parameter int unsigned WDT_TICK_CYCLES = `CSP_WDT_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire csp_pkg::csp_cmp_s cmpIn,
  input wire csp_pkg::csp_err_s loopErr,
  input wire logic [15:0] batteryVoltage,
  output logic adapterValid,
  output logic adapterSwitchOn,
  output logic reverseBlockSwitchOn,
  output logic batterySwitchOn,
  output logic calibrationActive,
  output logic chargeEnabled,
  output logic [12:0] chargeCurrentTarget,
  output logic monitorSelectCharge,
  output logic currentMonitorValid,
  output logic highSideOn,
  output logic lowSideOn
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  localparam logic [7:0] REFRESH_START =
    8'(`CSP_PWM_PERIOD - 8'h01 - `CSP_PWM_REFRESH - `CSP_PWM_DEAD - `CSP_PWM_DEAD);
  localparam logic [15:0] SS_LAST = 16'(SS_STEP_CYCLES - 1);
  localparam logic [16:0] TICK_LAST = 17'(WDT_TICK_CYCLES - 1);
  localparam csp_pkg::csp_state_s RST_STATE = '{option: `CSP_OPT_RST,
    ps: csp_pkg::PS_BATT, pw: csp_pkg::PW_DEAD_LOW, default: '0};

  function automatic logic [15:0] strobe16(input logic [15:0] old,
                                           input logic [31:0] data, input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic [12:0] minOf(input logic [12:0] a, input logic [12:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] maxOf3(input csp_pkg::csp_err_s e);
    logic [7:0] m;
    m = e.inputLoop;
    if (e.chargeLoop > m) begin
      m = e.chargeLoop;
    end
    if (e.voltageLoop > m) begin
      m = e.voltageLoop;
    end
    return m;
  endfunction

  function automatic logic [15:0] depletion(input logic [15:0] volt, input logic [1:0] sel);
    logic [15:0] k;
    logic [31:0] prod;
    k = `CSP_DEPL_K0;
    if (sel == 2'h1) begin
      k = `CSP_DEPL_K1;
    end else if (sel == 2'h2) begin
      k = `CSP_DEPL_K2;
    end else if (sel == 2'h3) begin
      k = `CSP_DEPL_K3;
    end
    prod = volt * k;
    return prod[29:14];
  endfunction

  csp_pkg::csp_state_s r;
  csp_pkg::csp_state_s n;
  csp_pkg::csp_cmp_s cmp;
  logic awTake, wTake, wrFire, wrOption, wrVolt, wrCurr, wrInCur, wrMapped;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic [15:0] newOption;
  logic [15:0] depletionLevel;
  logic belowDepletion, calibDone, dacValid, startOk, stopNow;
  logic wdOn, expireNow, demand, refreshCut, cycleEnd;
  logic [17:0] wdLimit;
  logic [12:0] currLimit;
  logic [7:0] rampLevel;

  // ----------------------------------------
  // Bus write path
  // ----------------------------------------
  assign cmp = r.cmpFilt;
  assign awready = ce & ~r.awHeld & ~r.bValid;
  assign wready = ce & ~r.wHeld & ~r.bValid;
  assign arready = ce & ~r.rValid;
  assign awTake = awvalid & awready;
  assign wTake = wvalid & wready;
  assign wrFire = ce & (r.awHeld | awTake) & (r.wHeld | wTake);
  assign wrAddr = r.awHeld ? r.awAddr : awaddr;
  assign wrData = r.wHeld ? r.wData : wdata;
  assign wrStrb = r.wHeld ? r.wStrb : wstrb;
  assign wrOption = wrFire & (wrAddr == `CSP_OFS_OPTION);
  assign wrVolt = wrFire & (wrAddr == `CSP_OFS_VOLT);
  assign wrCurr = wrFire & (wrAddr == `CSP_OFS_CURR);
  assign wrInCur = wrFire & (wrAddr == `CSP_OFS_INCUR);
  assign wrMapped = wrOption | wrVolt | wrCurr | wrInCur;
  assign newOption = strobe16(r.option, wrData, wrStrb);

  // ----------------------------------------
  // Supervision terms
  // ----------------------------------------
  // threshold from fraction field
  assign depletionLevel = depletion(r.voltSet, r.option[`CSP_OPT_DEPL_LO +: 2]);
  assign belowDepletion = batteryVoltage < depletionLevel;
  assign calibDone = (r.ps == csp_pkg::PS_BATT) & r.option[`CSP_OPT_CALIB]
                     & r.adapterValid & belowDepletion;
  assign dacValid = (r.voltSet != 16'h0000) & ((r.voltSet & ~`CSP_VOLT_MASK) == 16'h0000)
                    & (r.voltSet <= `CSP_VOLT_MAX)
                    & (r.currSet != 16'h0000) & ((r.currSet & ~`CSP_CURR_MASK) == 16'h0000)
                    & (r.inCurSet != 16'h0000) & ((r.inCurSet & ~`CSP_INCUR_MASK) == 16'h0000);
  assign startOk = ~r.option[`CSP_OPT_INHIBIT] & cmp.limitAboveHigh & dacValid
                   & r.adapterValid & (r.ps == csp_pkg::PS_ADPT) & cmp.gateDriveGood
                   & ~cmp.batteryOvervoltage & ~cmp.thermalShutdown
                   & ~cmp.inputOvercurrent & ~cmp.shortDetected & ~r.wdExpired;
  assign stopNow = r.option[`CSP_OPT_INHIBIT] | ~cmp.limitAboveLow | ~dacValid
                   | ~r.adapterValid | (r.ps != csp_pkg::PS_ADPT)
                   | cmp.batteryOvervoltage | cmp.thermalShutdown
                   | cmp.inputOvercurrent | cmp.shortDetected | r.wdExpired;
  assign currLimit = r.currSet[12:0];
  assign wdOn = r.option[`CSP_OPT_WDT_LO +: 2] != 2'h0;
  assign wdLimit = (r.option[`CSP_OPT_WDT_LO +: 2] == 2'h1) ? `CSP_WDT_MS_SHORT :
                   (r.option[`CSP_OPT_WDT_LO +: 2] == 2'h2) ? `CSP_WDT_MS_MID :
                   `CSP_WDT_MS_LONG;
  assign expireNow = wdOn & ~r.wdExpired & (r.tickCnt == TICK_LAST)
                     & (r.wdMs == wdLimit - 18'h00001);
  assign rampLevel = 8'(`CSP_RAMP_OFFSET + r.rampCnt);
  assign demand = maxOf3(loopErr) > rampLevel;
  // late in cycle a low bootstrap forces refresh
  assign refreshCut = cmp.bootstrapLow & (r.rampCnt >= REFRESH_START);
  assign cycleEnd = r.rampCnt == (`CSP_PWM_PERIOD - 8'h01);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    if (ce) begin
      n.sync1 = cmpIn;
      n.sync2 = r.sync1;
      n.sync3 = r.sync2;
      n.cmpFilt = (r.sync2 & r.sync3) | (r.cmpFilt & (r.sync2 ^ r.sync3));
      if (awTake) begin
        n.awHeld = 1'b1;
        n.awAddr = awaddr;
      end
      if (wTake) begin
        n.wHeld = 1'b1;
        n.wData = wdata;
        n.wStrb = wstrb;
      end
      if (r.bValid && bready) begin
        n.bValid = 1'b0;
      end
      // self-clear, a same-cycle host write overrides
      if (calibDone) begin
        n.option[`CSP_OPT_CALIB] = 1'b0;
      end
      if (wrFire) begin
        n.awHeld = 1'b0;
        n.wHeld = 1'b0;
        n.bValid = 1'b1;
        n.bResp = wrMapped ? 2'h0 : 2'h2;
      end
      if (wrOption) begin
        n.option = newOption;
      end
      if (wrVolt) begin
        n.voltSet = strobe16(r.voltSet, wrData, wrStrb);
      end
      if (wrCurr) begin
        n.currSet = strobe16(r.currSet, wrData, wrStrb);
      end
      if (wrInCur) begin
        n.inCurSet = strobe16(r.inCurSet, wrData, wrStrb);
      end
      if (r.rValid && rready) begin
        n.rValid = 1'b0;
      end
      if (arvalid && arready) begin
        n.rValid = 1'b1;
        n.rResp = 2'h0;
        n.rData = 32'h0000_0000;
        if (araddr == `CSP_OFS_OPTION) begin
          n.rData[15:0] = r.option;
        end else if (araddr == `CSP_OFS_VOLT) begin
          n.rData[15:0] = r.voltSet;
        end else if (araddr == `CSP_OFS_CURR) begin
          n.rData[15:0] = r.currSet;
        end else if (araddr == `CSP_OFS_INCUR) begin
          n.rData[15:0] = r.inCurSet;
        end else if (araddr == `CSP_OFS_STATUS) begin
          n.rData[`CSP_ST_CHARGE] = r.chargeOn;
          n.rData[`CSP_ST_WDEXP] = r.wdExpired;
          n.rData[`CSP_ST_ADPVALID] = r.adapterValid;
          n.rData[`CSP_ST_ADPSW] = r.ps == csp_pkg::PS_ADPT;
          n.rData[`CSP_ST_BATSW] = r.ps == csp_pkg::PS_BATT;
          n.rData[`CSP_ST_CALIB] = calibrationActive;
          n.rData[`CSP_ST_MONVALID] = r.monitorValid;
          n.rData[`CSP_ST_TARGET_LO +: 13] = chargeCurrentTarget;
        end else begin
          n.rResp = 2'h2;
        end
      end
      n.adapterValid = cmp.supplyOk & cmp.adapterAboveLow & ~cmp.adapterAboveOvp;
      n.monitorValid = cmp.supplyOk & cmp.adapterAboveReset;
      // Break-before-make on every selector change
      case (r.ps)
        csp_pkg::PS_BATT: begin
          if (r.adapterValid && (!r.option[`CSP_OPT_CALIB] || belowDepletion)) begin
            n.ps = csp_pkg::PS_TO_ADPT;
            n.bbmCnt = 8'h00;
          end
        end
        csp_pkg::PS_TO_ADPT: begin
          n.bbmCnt = r.bbmCnt + 8'h01;
          if (r.bbmCnt == `CSP_BBM_CYCLES - 8'h01) begin
            n.ps = csp_pkg::PS_ADPT;
          end
        end
        csp_pkg::PS_ADPT: begin
          if (!r.adapterValid || r.option[`CSP_OPT_CALIB]) begin
            n.ps = csp_pkg::PS_TO_BATT;
            n.bbmCnt = 8'h00;
          end
        end
        default: begin
          n.bbmCnt = r.bbmCnt + 8'h01;
          if (r.bbmCnt == `CSP_BBM_CYCLES - 8'h01) begin
            n.ps = csp_pkg::PS_BATT;
          end
        end
      endcase
      // start on upper level, stop on lower
      if (!r.chargeOn) begin
        if (startOk) begin
          n.chargeOn = 1'b1;
          n.ssTarget = minOf(`CSP_SS_START, currLimit);
          n.ssCnt = 16'h0000;
        end
      end else if (stopNow) begin
        // inhibit, watchdog, both among the stop terms
        n.chargeOn = 1'b0;
      end else if (r.ssTarget < currLimit) begin
        // fixed step interval up to the limit
        if (r.ssCnt == SS_LAST) begin
          n.ssCnt = 16'h0000;
          n.ssTarget = minOf(13'(r.ssTarget + `CSP_SS_STEP), currLimit);
        end else begin
          n.ssCnt = r.ssCnt + 16'h0001;
        end
      end else begin
        n.ssTarget = currLimit;
      end
      // timer restarted by voltage or current writes
      if (wrVolt || wrCurr) begin
        n.tickCnt = 17'h00000;
        n.wdMs = 18'h00000;
      end else if (wdOn && !r.wdExpired) begin
        if (r.tickCnt == TICK_LAST) begin
          n.tickCnt = 17'h00000;
          n.wdMs = r.wdMs + 18'h00001;
        end else begin
          n.tickCnt = r.tickCnt + 17'h00001;
        end
      end
      // resume by rewrite; registers are left alone
      if (wrVolt || wrCurr || (wrOption && newOption[`CSP_OPT_WDT_LO +: 2] == 2'h0)) begin
        n.wdExpired = 1'b0;
      end
      if (expireNow) begin
        n.wdExpired = 1'b1;
      end
      n.rampCnt = cycleEnd ? 8'h00 : r.rampCnt + 8'h01;
      if (!r.chargeOn || cmp.batteryOvervoltage) begin
        n.pw = csp_pkg::PW_DEAD_LOW;
        n.deadCnt = 8'h00;
        n.highSideOn = 1'b0;
        n.lowSideOn = 1'b0;
      end else begin
        case (r.pw)
          csp_pkg::PW_DEAD_LOW: begin
            n.deadCnt = r.deadCnt + 8'h01;
            if (r.deadCnt >= `CSP_PWM_DEAD - 8'h01) begin
              n.deadCnt = 8'h00;
              if (demand && !refreshCut) begin
                n.pw = csp_pkg::PW_HIGH;
                n.highSideOn = 1'b1;
              end else begin
                n.pw = csp_pkg::PW_LOW;
                n.lowSideOn = 1'b1;
              end
            end
          end
          csp_pkg::PW_HIGH: begin
            if (!demand || refreshCut) begin
              n.pw = csp_pkg::PW_DEAD_HIGH;
              n.highSideOn = 1'b0;
              n.deadCnt = 8'h00;
            end
          end
          csp_pkg::PW_DEAD_HIGH: begin
            n.deadCnt = r.deadCnt + 8'h01;
            if (r.deadCnt >= `CSP_PWM_DEAD - 8'h01) begin
              n.pw = csp_pkg::PW_LOW;
              n.lowSideOn = 1'b1;
              n.deadCnt = 8'h00;
            end
          end
          default: begin
            if (cycleEnd) begin
              n.pw = csp_pkg::PW_DEAD_LOW;
              n.lowSideOn = 1'b0;
              n.deadCnt = 8'h00;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bvalid = r.bValid;
  assign bresp = r.bResp;
  assign rvalid = r.rValid;
  assign rdata = r.rData;
  assign rresp = r.rResp;
  assign adapterValid = r.adapterValid;
  assign adapterSwitchOn = r.ps == csp_pkg::PS_ADPT;
  assign reverseBlockSwitchOn = r.ps == csp_pkg::PS_ADPT;
  assign batterySwitchOn = r.ps == csp_pkg::PS_BATT;
  assign calibrationActive = r.option[`CSP_OPT_CALIB] & (r.ps == csp_pkg::PS_BATT);
  assign chargeEnabled = r.chargeOn;
  assign chargeCurrentTarget = r.chargeOn ? r.ssTarget : 13'h0000;
  assign monitorSelectCharge = r.option[`CSP_OPT_MONSEL];
  assign currentMonitorValid = r.monitorValid;
  assign highSideOn = r.highSideOn;
  assign lowSideOn = r.lowSideOn;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_calibEnter;
    ce && r.ps == csp_pkg::PS_ADPT && r.option[`CSP_OPT_CALIB]
      |=> r.ps == csp_pkg::PS_TO_BATT ##[4:6] batterySwitchOn && !adapterSwitchOn;
  endproperty
  a_calibEnter: assert property (p_calibEnter) else $error("calibration did not switch");
  property p_calibClear;
    ce && calibDone && !wrOption |=> !r.option[`CSP_OPT_CALIB];
  endproperty
  a_calibClear: assert property (p_calibClear) else $error("calibration bit kept");
  property p_inhibit;
    ce && r.option[`CSP_OPT_INHIBIT] |=> !chargeEnabled;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("charging while inhibited");
  property p_limitLow;
    ce && chargeEnabled && !cmp.limitAboveLow |=> !chargeEnabled;
  endproperty
  a_limitLow: assert property (p_limitLow) else $error("charging below low limit");
  property p_watchdogStop;
    ce && r.wdExpired |=> !chargeEnabled;
  endproperty
  a_watchdogStop: assert property (p_watchdogStop) else $error("charging after timeout");
  property p_softStart;
    $rose(chargeEnabled) |-> chargeCurrentTarget == minOf(`CSP_SS_START, currLimit);
  endproperty
  a_softStart: assert property (p_softStart) else $error("bad soft start value");
  property p_step;
    ce && r.chargeOn && !stopNow && r.ssCnt == SS_LAST && r.ssTarget < currLimit
      |=> r.ssTarget == minOf(13'($past(r.ssTarget) + `CSP_SS_STEP), currLimit);
  endproperty
  a_step: assert property (p_step) else $error("soft start step wrong");
  property p_wdDisable;
    ce && wrOption && newOption[`CSP_OPT_WDT_LO +: 2] == 2'h0 && !expireNow |=> !r.wdExpired;
  endproperty
  a_wdDisable: assert property (p_wdDisable) else $error("disable did not resume");
  property p_refresh;
    ce && cmp.bootstrapLow && highSideOn && r.rampCnt >= REFRESH_START |=> !highSideOn;
  endproperty
  a_refresh: assert property (p_refresh) else $error("no bootstrap refresh");
  property p_noOverlap;
    !(highSideOn && lowSideOn);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("both switches on");
  property p_deadTime;
    $fell(highSideOn) |-> !lowSideOn;
  endproperty
  a_deadTime: assert property (p_deadTime) else $error("no dead time");
  property p_adapterValid;
    ce |=> adapterValid == ($past(cmp.supplyOk) && $past(cmp.adapterAboveLow)
                            && !$past(cmp.adapterAboveOvp));
  endproperty
  a_adapterValid: assert property (p_adapterValid) else $error("adapter valid wrong");
endmodule

// File: verification/csp_env_model.sv
// ----------------------------------------
// Analog side: comparators as plain levels
// ----------------------------------------
module csp_env_model (
  input wire logic batteryHigh,
  input wire logic bootstrapLow,
  output csp_pkg::csp_cmp_s cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  assign cmp = {4'he, 2'h3, batteryHigh, 3'h0, 1'b1, bootstrapLow};
endmodule

// File: verification/tb_top.sv
`include "csp_defs.svh"
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, awvalid, wvalid, bready, arvalid, rready, fault, boot, awready, wready;
  logic bvalid, arready, rvalid, adapterValid, adapterSwitchOn, reverseBlockSwitchOn;
  logic batterySwitchOn, calibrationActive, chargeEnabled, monitorSelectCharge;
  logic currentMonitorValid, highSideOn, lowSideOn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [12:0] chargeCurrentTarget;
  logic [23:0] loopErr;
  logic [15:0] batteryVoltage;
  csp_pkg::csp_cmp_s cmpIn;
  int miscompares, testsRun, n;
  csp_env_model i_csp_env_model (.batteryHigh(fault), .bootstrapLow(boot), .cmp(cmpIn));
  // One-cycle tick keeps the short timeout at 44000 cycles
  csp_charger_supervisor #(.SS_STEP_CYCLES(8), .WDT_TICK_CYCLES(1)) i_csp_charger_supervisor (
    .clk, .rst_n, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cmpIn,
    .loopErr, .batteryVoltage, .adapterValid, .adapterSwitchOn, .reverseBlockSwitchOn,
    .batterySwitchOn, .calibrationActive, .chargeEnabled, .chargeCurrentTarget,
    .monitorSelectCharge, .currentMonitorValid, .highSideOn, .lowSideOn);
  // ----------------------------------------
  // Bus tasks and closing
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic ad, wd;
    ad = 0;
    wd = 0;
    // Fresh edge, so back-to-back calls never assign bready twice in one step
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ad |= awvalid && awready;
      wd |= wvalid && wready;
      @(posedge clk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // Soft start seen from a fresh charge start
  task automatic ss;
    for (n = 0; n < 900 && chargeEnabled !== 1'b1; n++) @(negedge clk);
    `CHK("start", 13'h0080, chargeCurrentTarget)
    for (n = 0; n < 99 && chargeCurrentTarget === 13'h0080; n++) @(negedge clk);
    `CHK("step", 13'h00c0, chargeCurrentTarget)
    for (n = 0; n < 200 && chargeCurrentTarget !== 13'h0200; n++) @(negedge clk);
    `CHK("limit", 13'h0200, chargeCurrentTarget)
    @(posedge clk);
  endtask
  // Switch activity over one full ramp period, after a period to settle
  task automatic pwm(input logic [23:0] e, input logic b, input logic [1:0] x);
    logic [1:0] seen;
    seen = 2'b00;
    loopErr <= e;
    boot <= b;
    repeat (150) @(negedge clk);
    repeat (140) begin
      @(negedge clk);
      seen |= {highSideOn, lowSideOn};
    end
    `CHK("pwmSeen", x, seen)
    @(posedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Generous span; the short watchdog alone takes 44000 of the 60000 cycles
  initial begin
    #600000;
    miscompares++;
    conclude();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, fault, boot, awaddr, araddr} = '0;
    {wdata, wstrb} = '0;
    ce = 1;
    loopErr = 24'h404040;
    batteryVoltage = 16'h3000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CSP_OFS_OPTION);
    `CHK("optReset", 32'h00006000, d)
    wr(`CSP_OFS_VOLT, 16'h3000);
    `CHK("wrResp", 2'b00, r)
    wr(`CSP_OFS_CURR, 16'h0200);
    wr(`CSP_OFS_INCUR, 16'h0400);
    ss();
    fault <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK("ovpStop", 1'b0, chargeEnabled)
    `CHK("ovpGate", 2'b00, {highSideOn, lowSideOn})
    `CHK("adpValid", 1'b1, adapterValid)
    `CHK("monValid", 1'b1, currentMonitorValid)
    @(posedge clk);
    fault <= 1'b0;
    ss();
    pwm(24'h000000, 1'b0, 2'b01);
    pwm(24'h000040, 1'b0, 2'b11);
    pwm(24'hff0000, 1'b0, 2'b10);
    pwm(24'hff0000, 1'b1, 2'b11);
    wr(`CSP_OFS_OPTION, 16'h6021);
    @(negedge clk);
    `CHK("inhibit", 1'b0, chargeEnabled)
    `CHK("monSel", 1'b1, monitorSelectCharge)
    @(posedge clk);
    rd(8'h20);
    `CHK("unmapped", 2'b10, r)
    wr(`CSP_OFS_OPTION, 16'h6041);
    for (n = 0; n < 99 && batterySwitchOn !== 1'b1; n++) @(negedge clk);
    `CHK("calibOn", 1'b1, calibrationActive)
    `CHK("adpOff", 1'b0, adapterSwitchOn)
    `CHK("rbOff", 1'b0, reverseBlockSwitchOn)
    @(posedge clk);
    batteryVoltage <= 16'h1000;
    for (n = 0; n < 99 && adapterSwitchOn !== 1'b1; n++) @(negedge clk);
    `CHK("batOff", 1'b0, batterySwitchOn)
    `CHK("rbOn", 1'b1, reverseBlockSwitchOn)
    @(posedge clk);
    rd(`CSP_OFS_OPTION);
    `CHK("autoClear", 32'h00006001, d)
    // Short watchdog, restarted by a current write once charging
    wr(`CSP_OFS_OPTION, 16'h2000);
    ss();
    wr(`CSP_OFS_CURR, 16'h0200);
    for (n = 0; n < 45000 && chargeEnabled === 1'b1; n++) @(negedge clk);
    `CHK("wdStop", 1'b0, chargeEnabled)
    `CHK("wdTime", 1'b1, (n >= 43998) && (n <= 44004))
    rd(`CSP_OFS_STATUS);
    `CHK("wdFlag", 1'b1, d[1])
    rd(`CSP_OFS_VOLT);
    `CHK("wdKeep", 32'h00003000, d)
    wr(`CSP_OFS_OPTION, 16'h0000);
    ss();
    rd(`CSP_OFS_STATUS);
    `CHK("wdResume", 1'b0, d[1])
    conclude();
  end
endmodule
